// *** tapsel_pkg.sv ***
// constants for the test access port select block
// assumes a plain register port with 16-bit addresses and 16-bit data
package tapsel_pkg;
   localparam int          TAPSEL_AW         = 16;
   localparam int          TAPSEL_DW         = 16;
   // register offsets
   localparam logic [15:0] TAPSEL_PULL_OFS   = 16'h1C18;
   localparam logic [15:0] TAPSEL_STAT_OFS   = 16'h1C1C;
   // pull disable fields, 1 turns the pull-up off
   localparam int          TAPSEL_PD_SEL_BIT = 0;
   localparam int          TAPSEL_PD_EVT_BIT = 1;
   localparam logic [15:0] TAPSEL_PULL_RST   = 16'h0000;
   // status fields
   localparam int          TAPSEL_ST_ROUTE   = 0;
   localparam int          TAPSEL_ST_TRST    = 1;
   localparam int          TAPSEL_ST_SEL_LVL = 2;
   localparam int          TAPSEL_ST_EVT_LVL = 3;
   localparam logic        TAPSEL_ROUTE_RST  = 1'b0;
endpackage

// *** tapsel_top.sv ***
// test access port select: scan routing capture, event pins, pull-up control
// assumes tck, test reset and pins are asynchronous to clk; tck well below clk/4
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module tapsel_top (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_b,
   // register port
   input  wire logic [tapsel_pkg::TAPSEL_AW-1:0] reg_addr,
   input  wire logic [tapsel_pkg::TAPSEL_DW-1:0] reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [tapsel_pkg::TAPSEL_DW-1:0] reg_rdata,
   // scan pins from the probe
   input  wire logic                           tck_pin,
   input  wire logic                           test_rst_pin_b,
   input  wire logic                           tms_pin,
   input  wire logic                           tdi_pin,
   output logic                                tdo_pin,
   // event pins
   input  wire logic                           tap_select_event_pin_i,
   output logic                                tap_select_event_pin_o,
   output logic                                tap_select_event_pin_oe,
   input  wire logic                           emulator_event_pin_i,
   output logic                                emulator_event_pin_o,
   output logic                                emulator_event_pin_oe,
   // pull-up enables
   output logic                                internal_pullup_sel_en,
   output logic                                internal_pullup_evt_en,
   // emulation logic side
   input  wire logic                           emu_sel_evt_out,
   input  wire logic                           emu_sel_evt_drive,
   input  wire logic                           emu_evt_out,
   input  wire logic                           emu_evt_drive,
   output logic                                emu_sel_evt_level,
   output logic                                emu_evt_level,
   // tap side, one-cycle steps carry sampled tms and tdi
   output logic                                taps_rst_b,
   output logic                                tap_tms,
   output logic                                tap_tdi,
   output logic                                bscan_step,
   output logic                                emu_step,
   input  wire logic                           bscan_tdo,
   input  wire logic                           emu_tdo
);
   import tapsel_pkg::*;

   logic       rst_q_ff, rst_sync_b;
   logic [1:0] tck_sy_ff, trst_sy_ff, tms_sy_ff, tdi_sy_ff, sel_sy_ff, evt_sy_ff;
   logic       tck_q_ff, trst_q_ff;
   logic       tck_rise, tck_fall, trst_rise, trst_s, sel_s;
   logic       route_ff;
   logic [15:0] pull_ff;
   logic       written_ff;
   logic       tms_ff, tdi_ff, bstep_ff, estep_ff, tdo_ff, trst_ff;
   logic       sel_o_ff, sel_oe_ff, evt_o_ff, evt_oe_ff;
   logic [15:0] rdata_ff, nxt_rdata;

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_q_ff   <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_q_ff   <= 1'b1;
         rst_sync_b <= rst_q_ff;
      end
   end

   // pin synchronisers, only bit 1 is read by logic
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         tck_sy_ff  <= 2'h0;
         trst_sy_ff <= 2'h0;
         tms_sy_ff  <= 2'h0;
         tdi_sy_ff  <= 2'h0;
         sel_sy_ff  <= 2'h0;
         evt_sy_ff  <= 2'h0;
      end else begin
         tck_sy_ff  <= {tck_sy_ff[0], tck_pin};
         trst_sy_ff <= {trst_sy_ff[0], test_rst_pin_b};
         tms_sy_ff  <= {tms_sy_ff[0], tms_pin};
         tdi_sy_ff  <= {tdi_sy_ff[0], tdi_pin};
         sel_sy_ff  <= {sel_sy_ff[0], tap_select_event_pin_i};
         evt_sy_ff  <= {evt_sy_ff[0], emulator_event_pin_i};
      end
   end

   assign trst_s = trst_sy_ff[1];
   assign sel_s  = sel_sy_ff[1];

   // edge detection on synchronised tck and test reset
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         tck_q_ff  <= 1'b0;
         trst_q_ff <= 1'b0;
      end else begin
         tck_q_ff  <= tck_sy_ff[1];
         trst_q_ff <= trst_s;
      end
   end

   assign tck_rise  = tck_sy_ff[1] & ~tck_q_ff;
   assign tck_fall  = ~tck_sy_ff[1] & tck_q_ff;
   assign trst_rise = trst_s & ~trst_q_ff;

   // routing choice caught on test reset rising, held otherwise
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         route_ff <= TAPSEL_ROUTE_RST;
      end else if (trst_rise) begin
         route_ff <= sel_s;
      end
   end

   // tms and tdi sampled on rising tck, step sent to the chosen tap
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         tms_ff   <= 1'b0;
         tdi_ff   <= 1'b0;
         bstep_ff <= 1'b0;
         estep_ff <= 1'b0;
         trst_ff  <= 1'b0;
      end else begin
         if (tck_rise && trst_s) begin
            tms_ff <= tms_sy_ff[1];
            tdi_ff <= tdi_sy_ff[1];
         end
         bstep_ff <= tck_rise & trst_s & ~route_ff;
         estep_ff <= tck_rise & trst_s & route_ff;
         trst_ff  <= trst_s;
      end
   end

   // tdo follows the chosen tap on falling tck
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         tdo_ff <= 1'b0;
      end else if (tck_fall && trst_s) begin
         tdo_ff <= route_ff ? emu_tdo : bscan_tdo;
      end
   end

   // event pin drivers, select pin only driven once test reset is high
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         sel_o_ff  <= 1'b0;
         sel_oe_ff <= 1'b0;
         evt_o_ff  <= 1'b0;
         evt_oe_ff <= 1'b0;
      end else begin
         sel_o_ff  <= emu_sel_evt_out;
         sel_oe_ff <= emu_sel_evt_drive & trst_s;
         evt_o_ff  <= emu_evt_out;
         evt_oe_ff <= emu_evt_drive;
      end
   end

   // pull disable register
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         pull_ff    <= TAPSEL_PULL_RST;
         written_ff <= 1'b0;
      end else if (reg_wr && reg_addr == TAPSEL_PULL_OFS) begin
         pull_ff    <= reg_wdata;
         written_ff <= 1'b1;
      end
   end

   // read decode, unmapped reads give zero
   always_comb begin
      nxt_rdata = 16'h0000;
      if (reg_rd && reg_addr == TAPSEL_PULL_OFS) begin
         nxt_rdata = pull_ff;
      end else if (reg_rd && reg_addr == TAPSEL_STAT_OFS) begin
         nxt_rdata[TAPSEL_ST_ROUTE]   = route_ff;
         nxt_rdata[TAPSEL_ST_TRST]    = trst_s;
         nxt_rdata[TAPSEL_ST_SEL_LVL] = sel_s;
         nxt_rdata[TAPSEL_ST_EVT_LVL] = evt_sy_ff[1];
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // outputs
   assign reg_rdata               = rdata_ff;
   assign tdo_pin                 = tdo_ff;
   assign tap_select_event_pin_o  = sel_o_ff;
   assign tap_select_event_pin_oe = sel_oe_ff;
   assign emulator_event_pin_o    = evt_o_ff;
   assign emulator_event_pin_oe   = evt_oe_ff;
   assign internal_pullup_sel_en  = ~pull_ff[TAPSEL_PD_SEL_BIT];
   assign internal_pullup_evt_en  = ~pull_ff[TAPSEL_PD_EVT_BIT];
   assign emu_sel_evt_level       = sel_s;
   assign emu_evt_level           = evt_sy_ff[1];
   assign taps_rst_b              = trst_ff;
   assign tap_tms                 = tms_ff;
   assign tap_tdi                 = tdi_ff;
   assign bscan_step              = bstep_ff;
   assign emu_step                = estep_ff;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_b);

   sequence s_trst_rise;
      !trst_s ##1 trst_s;
   endsequence
   sequence s_tck_rise_on;
      trst_s && tck_rise;
   endsequence

   a_route_capture: assert property (s_trst_rise |=> route_ff == $past(sel_s))
      else $error("route not captured on test reset rise");
   a_route_hold: assert property (trst_s [*2] |=> $stable(route_ff))
      else $error("route changed while test reset high");
   a_route_bscan: assert property (s_tck_rise_on ##0 !route_ff |=> bscan_step && !emu_step)
      else $error("boundary-scan step missing");
   a_route_emu: assert property (s_tck_rise_on ##0 route_ff |=> emu_step && !bscan_step)
      else $error("emulation step missing");
   a_func_ignore: assert property (!trst_s |=> !bscan_step && !emu_step)
      else $error("tap stepped in functional mode");
   a_sample_tms: assert property (s_tck_rise_on |=> tap_tms == $past(tms_sy_ff[1]) && tap_tdi == $past(tdi_sy_ff[1]))
      else $error("tms or tdi not sampled on rising tck");
   a_tdo_fall: assert property ($changed(tdo_pin) |-> $past(tck_fall))
      else $error("tdo changed without falling tck");
   a_sel_release: assert property (!trst_s |=> !tap_select_event_pin_oe)
      else $error("select pin driven while test reset low");
   a_evt_dir: assert property (emu_evt_drive |=> emulator_event_pin_oe && emulator_event_pin_o == $past(emu_evt_out))
      else $error("event pin not driven as asked");
   a_pull_write: assert property (reg_wr && reg_addr == TAPSEL_PULL_OFS |=>
      internal_pullup_sel_en == !$past(reg_wdata[0]) && internal_pullup_evt_en == !$past(reg_wdata[1]))
      else $error("pull-up enable not following write");
   a_pull_default: assert property (!written_ff |-> internal_pullup_sel_en && internal_pullup_evt_en)
      else $error("pull-up off before any write");
endmodule
`default_nettype wire

// *** tapsel_probe.sv ***
// probe model: drives test clock, test reset, mode and data pins
// assumes the bench resolves the select pin level from all drivers
`timescale 1ns/10ps
`default_nettype none
module tapsel_probe (
   // scan pins
   output logic tck,
   output logic trst_b,
   output logic tms,
   output logic tdi,
   // select pin drive
   output logic sel_oe,
   output logic sel_v
);
   logic tms_rise;
   logic tdi_rise;
   // idle: clock stands low, test reset held low
   initial begin
      {tck, trst_b, tms, tdi, sel_oe, sel_v, tms_rise, tdi_rise} = '0;
   end
   // test reset pulse with a select level presented on the pin
   // odd delays keep every pin change off the rising system clock edges
   task automatic trst_pulse(input logic sel);
      #2;
      sel_oe = 1'b1;
      sel_v  = sel;
      trst_b = 1'b0;
      #101 trst_b = 1'b1;
      #99 sel_oe = 1'b0;
   endtask
   // probe side drive of the select pin, off the system clock edges
   task automatic drive_sel(input logic oe, input logic lvl);
      #2;
      sel_oe = oe;
      sel_v  = lvl;
   endtask
   // pull test reset low again, back to functional mode
   task automatic hold_reset;
      #2 trst_b = 1'b0;
   endtask
   // n test clocks, off the rising system clock edges; clock idles low after
   task automatic frame(input int n);
      #4;
      for (int i = 0; i < n; i++) begin
         tms = 1'($urandom);
         tdi = 1'($urandom);
         #32 tck = 1'b1;
         tms_rise = tms;
         tdi_rise = tdi;
         #32 tck = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** test_access_port_select_bench.sv ***
// bench for the test access port select block with a probe model
// assumes tapsel_probe and tapsel_top are compiled before it
`timescale 1ns/10ps
`default_nettype none
module test_access_port_select_bench;
   import tapsel_pkg::*;
   logic        clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
   logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata, v;
   logic        tck_pin, test_rst_pin_b, tms_pin, tdi_pin, tdo_pin, p_oe, p_v;
   logic        tap_select_event_pin_i, tap_select_event_pin_o, tap_select_event_pin_oe;
   logic        emulator_event_pin_i, emulator_event_pin_o, emulator_event_pin_oe;
   logic        internal_pullup_sel_en, internal_pullup_evt_en, emu_sel_evt_level, emu_evt_level;
   logic        emu_sel_evt_out = 0, emu_sel_evt_drive = 0, emu_evt_out = 0, emu_evt_drive = 0;
   logic        taps_rst_b, tap_tms, tap_tdi, bscan_step, emu_step, bscan_tdo = 0, emu_tdo = 0;
   logic        sel_last = 0, evt_last = 0;
   int          miscompares = 0, n_compared = 0, nb = 0, ne = 0, pull_m = 0;
   // clock and resolved pin levels, released lines without pull-up show the inverse
   always #4 clk = ~clk;
   assign tap_select_event_pin_i = tap_select_event_pin_oe ? tap_select_event_pin_o : p_oe ? p_v :
                                   internal_pullup_sel_en ? 1'b1 : ~sel_last;
   assign emulator_event_pin_i   = emulator_event_pin_oe ? emulator_event_pin_o :
                                   internal_pullup_evt_en ? 1'b1 : ~evt_last;
   always @(posedge clk) {sel_last, evt_last} <= {tap_select_event_pin_i, emulator_event_pin_i};
   tapsel_probe PRB (.tck(tck_pin), .trst_b(test_rst_pin_b), .tms(tms_pin), .tdi(tdi_pin),
                     .sel_oe(p_oe), .sel_v(p_v));
   tapsel_top DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
                   .tck_pin(tck_pin), .test_rst_pin_b(test_rst_pin_b),
                   .tms_pin(tms_pin), .tdi_pin(tdi_pin), .tdo_pin(tdo_pin),
                   .tap_select_event_pin_i(tap_select_event_pin_i),
                   .tap_select_event_pin_o(tap_select_event_pin_o),
                   .tap_select_event_pin_oe(tap_select_event_pin_oe),
                   .emulator_event_pin_i(emulator_event_pin_i),
                   .emulator_event_pin_o(emulator_event_pin_o),
                   .emulator_event_pin_oe(emulator_event_pin_oe),
                   .internal_pullup_sel_en(internal_pullup_sel_en),
                   .internal_pullup_evt_en(internal_pullup_evt_en),
                   .emu_sel_evt_out(emu_sel_evt_out), .emu_sel_evt_drive(emu_sel_evt_drive),
                   .emu_evt_out(emu_evt_out), .emu_evt_drive(emu_evt_drive),
                   .emu_sel_evt_level(emu_sel_evt_level), .emu_evt_level(emu_evt_level),
                   .taps_rst_b(taps_rst_b), .tap_tms(tap_tms), .tap_tdi(tap_tdi),
                   .bscan_step(bscan_step), .emu_step(emu_step),
                   .bscan_tdo(bscan_tdo), .emu_tdo(emu_tdo));
   // compare and report
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude;
      if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // register port cycles
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk) reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk) #1 chk("rdata idle", 16'h0000, reg_rdata);
      @(posedge clk);
   endtask
   task automatic pu_chk;
      chk("pullups", 16'(~pull_m & 3), {14'h0, internal_pullup_evt_en, internal_pullup_sel_en});
   endtask
   // step monitor: count steps per tap, check sampled mode and data
   always @(posedge clk) begin
      if (bscan_step) nb++;
      if (emu_step) ne++;
      if (bscan_step || emu_step) chk("tms tdi", {PRB.tms_rise, PRB.tdi_rise}, {tap_tms, tap_tdi});
   end
   initial begin
      #200000 miscompares++;
      conclude();
   end
   initial begin
      void'($urandom(32'h4EFE));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      pu_chk();
      wr(TAPSEL_STAT_OFS, 16'hFFFF);
      rd(TAPSEL_STAT_OFS, v);
      chk("status", 16'h000C, v);
      for (int i = 0; i < 6; i++) begin
         pull_m = $urandom & 16'hFFFF;
         wr(TAPSEL_PULL_OFS, 16'(pull_m));
         wr(16'h1C1A, 16'(~pull_m));
         rd(TAPSEL_PULL_OFS, v);
         chk("pull reg", 16'(pull_m), v);
         pu_chk();
         rd(16'h1C1A, v);
         chk("unmapped", 16'h0000, v);
      end
      pull_m = 0;
      wr(TAPSEL_PULL_OFS, 16'h0000);
      PRB.frame(4);
      chk("steps in reset", 16'h0000, 16'(nb + ne));
      for (int s = 0; s < 2; s++) begin
         PRB.trst_pulse(s[0]);
         @(posedge clk);
         nb = 0;
         ne = 0;
         v = 16'($urandom);
         bscan_tdo <= v[0];
         emu_tdo <= ~v[0];
         PRB.frame(5);
         repeat (6) @(posedge clk);
         chk("selected steps", 16'h0005, 16'(s ? ne : nb));
         chk("other steps", 16'h0000, 16'(s ? nb : ne));
         chk("tdo", 16'(s ? emu_tdo : bscan_tdo), 16'(tdo_pin));
         PRB.drive_sel(1'b1, ~s[0]);
         repeat (4) @(posedge clk);
         rd(TAPSEL_STAT_OFS, v);
         chk("route held", {13'h0, ~s[0], 1'b1, s[0]}, v & 16'h0007);
         chk("tap reset", 16'h0001, 16'(taps_rst_b));
         PRB.drive_sel(1'b0, 1'b0);
      end
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom & 1);
         {emu_evt_drive, emu_sel_evt_drive, emu_evt_out, emu_sel_evt_out} <= {2'b11, v[0], ~v[0]};
         repeat (4) @(posedge clk);
         chk("evt pin", {12'h0, 2'b11, v[0], ~v[0]}, {12'h0, emulator_event_pin_oe,
                tap_select_event_pin_oe, emulator_event_pin_o, tap_select_event_pin_o});
         chk("evt levels", {14'h0, v[0], ~v[0]}, {14'h0, emu_evt_level, emu_sel_evt_level});
      end
      emu_evt_drive <= 1'b0;
      PRB.hold_reset();
      repeat (5) @(posedge clk);
      #1 chk("released", 16'h0001, {13'h0, taps_rst_b, emulator_event_pin_oe, emu_evt_level});
      chk("sel oe in reset", 16'h0000, 16'(tap_select_event_pin_oe));
      conclude();
   end
endmodule
`default_nettype wire
